// File: sptp_defs.svh
`ifndef SPTP_DEFS_SVH
`define SPTP_DEFS_SVH
// register indices; byte address is four times the index
`define SPTP_IDX_PAT_CTRL 10'd64
`define SPTP_IDX_ERR_CNT 10'd65
`define SPTP_IDX_RST_OVR 10'd66
`define SPTP_IDX_PWR_OVR 10'd67
`define SPTP_IDX_IRQ_STS 10'd68
`define SPTP_IDX_IRQ_EN 10'd69
`define SPTP_IDX_IRQ_CLR 10'd70
// pattern_test_control fields
`define SPTP_PAT_CHK 6
`define SPTP_PAT_TYP_HI 3
`define SPTP_PAT_TYP_LO 2
`define SPTP_PAT_LPBK 1
`define SPTP_PAT_GEN 0
`define SPTP_PAT_WMASK 8'h4f
`define SPTP_TYP_PRBS7 2'b00
`define SPTP_TYP_PRBS11 2'b01
`define SPTP_TYP_PRBS23 2'b10
`define SPTP_TYP_PRBS31 2'b11
// phy_reset_override fields
`define SPTP_RST_RXCLKDN 7
`define SPTP_RST_TXCLKDN 6
`define SPTP_RST_RXPLLRST 5
`define SPTP_RST_TXPLLRST 4
`define SPTP_RST_RXINIT 3
`define SPTP_RST_TXINIT 2
`define SPTP_RST_RXHIZ 1
`define SPTP_RST_TXHIZ 0
`define SPTP_RST_WMASK 8'hff
// phy_power_override fields
`define SPTP_PWR_RXPD 0
`define SPTP_PWR_WMASK 8'h01
// reset values and counter codes
`define SPTP_REG_RESET 8'h00
`define SPTP_CNT_RESET 8'h00
`define SPTP_CNT_SAT 8'hfe
`define SPTP_CNT_UNLOCK 8'hff
// interrupt status bits
`define SPTP_IRQ_ERR 0
`define SPTP_IRQ_SAT 1
`define SPTP_IRQ_UNLOCK 2
`define SPTP_IRQ_BITS 3
// axi responses
`define SPTP_RESP_OKAY 2'b00
`define SPTP_RESP_SLVERR 2'b10
// generator seed after stop
`define SPTP_SEED 31'h7fffffff
`endif

// File: sptp_pkg.sv
package sptp_pkg;
  typedef logic [1:0] sptp_prbs_typ_t;
  typedef struct packed {
    logic rxClkDown;
    logic txClkDown;
    logic rxPllRst;
    logic txPllRst;
    logic rxPllInit;
    logic txPllInit;
    logic rxHiz;
    logic txHiz;
    logic rxPwrDn;
    logic nearLoop;
  } sptp_phy_ctrl_t;
endpackage

// File: sptp_lane_ctrl.sv
// Local design decisions: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "sptp_defs.svh"
// Notes on behaviour
// [RULE1] checker compares received data when enabled
// [RULE2] type field picks PRBS7/11/23/31 for both
// [RULE3] near-end loopback feeds transmit into receiver
// [RULE4] generator sends pattern only while bit set
// [RULE5] read-only eight-bit error counter, resets zero
// [RULE6] clearing checker enable clears the counter
// [RULE7] counter saturates at 254, never wraps
// [RULE8] value 255 means clock recovery unlocked
// [RULE9] software waits or times out on 255
// [RULE10] all-zero received stream counts as errors
// [RULE11] control writes take effect at once
// [RULE12] receive clock-down stops receive path
// [RULE13] transmit clock-down stops transmit path; code freezes only the running generator, txUserData still passes
// [RULE14] receive PLL held reset while bit set
// [RULE15] transmit PLL held reset while bit set
// [RULE16] init bits reinitialise the PLL settings
// [RULE17] high-impedance bits float the drivers
// [RULE18] receive power-down forces receive PMA down
module sptp_lane_ctrl
  import sptp_pkg::*;
#(
  parameter int W = 16,
  parameter int ADDR_W = 12
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [W-1:0] txUserData,
  output logic [W-1:0] txData,
  input wire logic [W-1:0] rxData,
  input wire logic rxValid,
  input wire logic cdrLocked,
  output sptp_phy_ctrl_t phyCtrl,
  output logic irq
);
  localparam int WARM = (31 + W - 1) / W;

  generate
    if (W < 1 || W > 64 || ADDR_W < 12) begin : g_badParam
      $error("sptp_lane_ctrl: W must be 1..64 and ADDR_W at least 12");
    end
  endgenerate

  function automatic logic tapBit(input logic [30:0] h, input sptp_prbs_typ_t typ);
    case (typ)
      `SPTP_TYP_PRBS7: tapBit = h[6] ^ h[5];
      `SPTP_TYP_PRBS11: tapBit = h[10] ^ h[8];
      `SPTP_TYP_PRBS23: tapBit = h[22] ^ h[17];
      default: tapBit = h[30] ^ h[27];
    endcase
  endfunction

  function automatic logic [30:0] lenMask(input sptp_prbs_typ_t typ);
    case (typ)
      `SPTP_TYP_PRBS7: lenMask = 31'h0000007f;
      `SPTP_TYP_PRBS11: lenMask = 31'h000007ff;
      `SPTP_TYP_PRBS23: lenMask = 31'h007fffff;
      default: lenMask = 31'h7fffffff;
    endcase
  endfunction

  function automatic logic [9:0] regIdx(input logic [ADDR_W-1:0] a);
    regIdx = a[11:2];
  endfunction

  logic [7:0] patCtrl_ff, rstOvr_ff, pwrOvr_ff, errCnt_ff;
  logic [`SPTP_IRQ_BITS-1:0] irqSts_ff, irqEn_ff;
  logic lockMeta_ff, lockSync_ff;
  logic [30:0] genSt_ff, chkH_ff;
  logic [W-1:0] txData_ff;
  logic [$clog2(WARM+1)-1:0] warm_ff;
  logic irq_ff;

  wire logic patChk = patCtrl_ff[`SPTP_PAT_CHK];
  wire logic patGen = patCtrl_ff[`SPTP_PAT_GEN];
  wire logic patLoop = patCtrl_ff[`SPTP_PAT_LPBK];
  wire sptp_prbs_typ_t patTyp = patCtrl_ff[`SPTP_PAT_TYP_HI:`SPTP_PAT_TYP_LO]; // RULE2

  // cdr lock comes from the analog side, so synchronise it
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      lockMeta_ff <= 1'b0;
      lockSync_ff <= 1'b0;
    end else begin
      lockMeta_ff <= cdrLocked;
      lockSync_ff <= lockMeta_ff;
    end
  end

  // ---------------- axi4-lite write path ----------------
  logic awRdy_ff, wRdy_ff, bValid_ff, awHave_ff, wHave_ff;
  logic [ADDR_W-1:0] awAddr_ff;
  logic [31:0] wData_ff;
  logic [3:0] wStrb_ff;
  logic [1:0] bResp_ff;
  wire logic doWrite = awHave_ff && wHave_ff && !bValid_ff;
  wire logic [9:0] wIdx = regIdx(awAddr_ff);
  wire logic wLane0 = doWrite && wStrb_ff[0];

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      awRdy_ff <= 1'b0;
      awHave_ff <= 1'b0;
      awAddr_ff <= '0;
    end else if (s_axi_awvalid && awRdy_ff) begin
      awRdy_ff <= 1'b0;
      awHave_ff <= 1'b1;
      awAddr_ff <= s_axi_awaddr;
    end else if (doWrite) begin
      awHave_ff <= 1'b0;
    end else if (!awHave_ff && !bValid_ff) begin
      awRdy_ff <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wRdy_ff <= 1'b0;
      wHave_ff <= 1'b0;
      wData_ff <= '0;
      wStrb_ff <= '0;
    end else if (s_axi_wvalid && wRdy_ff) begin
      wRdy_ff <= 1'b0;
      wHave_ff <= 1'b1;
      wData_ff <= s_axi_wdata;
      wStrb_ff <= s_axi_wstrb;
    end else if (doWrite) begin
      wHave_ff <= 1'b0;
    end else if (!wHave_ff && !bValid_ff) begin
      wRdy_ff <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      bValid_ff <= 1'b0;
      bResp_ff <= `SPTP_RESP_OKAY;
    end else if (doWrite) begin
      bValid_ff <= 1'b1;
      bResp_ff <= (wIdx >= `SPTP_IDX_PAT_CTRL && wIdx <= `SPTP_IDX_IRQ_CLR) ?
                  `SPTP_RESP_OKAY : `SPTP_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bValid_ff <= 1'b0;
    end
  end

  // writes land on the next edge, traffic or not
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      patCtrl_ff <= `SPTP_REG_RESET;
      rstOvr_ff <= `SPTP_REG_RESET;
      pwrOvr_ff <= `SPTP_REG_RESET;
      irqEn_ff <= '0;
    end else if (wLane0) begin
      if (wIdx == `SPTP_IDX_PAT_CTRL)
        patCtrl_ff <= wData_ff[7:0] & `SPTP_PAT_WMASK; // RULE11
      if (wIdx == `SPTP_IDX_RST_OVR)
        rstOvr_ff <= wData_ff[7:0] & `SPTP_RST_WMASK;
      if (wIdx == `SPTP_IDX_PWR_OVR)
        pwrOvr_ff <= wData_ff[7:0] & `SPTP_PWR_WMASK;
      if (wIdx == `SPTP_IDX_IRQ_EN)
        irqEn_ff <= wData_ff[`SPTP_IRQ_BITS-1:0];
    end
  end

  // ---------------- axi4-lite read path ----------------
  logic arRdy_ff, rValid_ff;
  logic [31:0] rData_ff;
  logic [1:0] rResp_ff;
  wire logic [9:0] rIdx = regIdx(s_axi_araddr);

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      arRdy_ff <= 1'b0;
      rValid_ff <= 1'b0;
      rData_ff <= '0;
      rResp_ff <= `SPTP_RESP_OKAY;
    end else if (s_axi_arvalid && arRdy_ff) begin
      arRdy_ff <= 1'b0;
      rValid_ff <= 1'b1;
      rResp_ff <= `SPTP_RESP_OKAY;
      case (rIdx)
        `SPTP_IDX_PAT_CTRL: rData_ff <= {24'h000000, patCtrl_ff};
        `SPTP_IDX_ERR_CNT: rData_ff <= {24'h000000, errCnt_ff};
        `SPTP_IDX_RST_OVR: rData_ff <= {24'h000000, rstOvr_ff};
        `SPTP_IDX_PWR_OVR: rData_ff <= {24'h000000, pwrOvr_ff};
        `SPTP_IDX_IRQ_STS: rData_ff <= {29'h00000000, irqSts_ff};
        `SPTP_IDX_IRQ_EN: rData_ff <= {29'h00000000, irqEn_ff};
        `SPTP_IDX_IRQ_CLR: rData_ff <= 32'h00000000;
        default: begin
          rData_ff <= 32'h00000000;
          rResp_ff <= `SPTP_RESP_SLVERR;
        end
      endcase
    end else if (rValid_ff && s_axi_rready) begin
      rValid_ff <= 1'b0;
    end else if (!rValid_ff) begin
      arRdy_ff <= 1'b1;
    end
  end

  // ---------------- pattern generator ----------------
  // frozen while the transmit clock is down or its pll is reset
  wire logic txRun = !rstOvr_ff[`SPTP_RST_TXCLKDN] && !rstOvr_ff[`SPTP_RST_TXPLLRST]; // RULE13
  logic [30:0] nxt_genSt;
  logic [W-1:0] nxt_genWord;

  always_comb begin
    nxt_genSt = genSt_ff;
    nxt_genWord = '0;
    // bit 0 of the word is sent first
    for (int i = 0; i < W; i++) begin
      nxt_genWord[i] = tapBit(nxt_genSt, patTyp); // RULE2
      nxt_genSt = {nxt_genSt[29:0], nxt_genWord[i]};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      genSt_ff <= `SPTP_SEED;
      txData_ff <= '0;
    end else if (!patGen) begin
      genSt_ff <= `SPTP_SEED;
      txData_ff <= txUserData; // RULE4
    end else if (txRun) begin
      genSt_ff <= nxt_genSt;
      txData_ff <= nxt_genWord; // RULE4
    end
  end

  // ---------------- pattern checker ----------------
  // loopback replaces the line input with our own transmit word
  wire logic [W-1:0] rxIn = patLoop ? txData_ff : rxData; // RULE3
  wire logic rxInValid = patLoop ? 1'b1 : rxValid;
  wire logic rxRun = !rstOvr_ff[`SPTP_RST_RXCLKDN] && !pwrOvr_ff[`SPTP_PWR_RXPD] &&
                     !rstOvr_ff[`SPTP_RST_RXPLLRST]; // RULE12 RULE18
  wire logic chkStep = patChk && lockSync_ff && rxRun && rxInValid; // RULE1
  logic [30:0] nxt_chkH;
  logic nxt_mis;

  always_comb begin
    nxt_chkH = chkH_ff;
    nxt_mis = 1'b0;
    for (int i = 0; i < W; i++) begin
      nxt_mis = nxt_mis | (tapBit(nxt_chkH, patTyp) != rxIn[i]);
      nxt_chkH = {nxt_chkH[29:0], rxIn[i]};
    end
  end

  // an all-zero window is the stuck state of the sequence
  wire logic wordErr = nxt_mis || ((nxt_chkH & lenMask(patTyp)) == 31'h00000000); // RULE10
  wire logic warmDone = (warm_ff == WARM[$bits(warm_ff)-1:0]);
  wire logic cntErr = chkStep && warmDone && wordErr;

  // history must refill before mismatches mean anything
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      chkH_ff <= '0;
      warm_ff <= '0;
    end else if (!patChk || !lockSync_ff) begin
      warm_ff <= '0;
    end else if (chkStep) begin
      chkH_ff <= nxt_chkH;
      if (!warmDone)
        warm_ff <= warm_ff + 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      errCnt_ff <= `SPTP_CNT_RESET; // RULE5
    end else if (!patChk) begin
      errCnt_ff <= `SPTP_CNT_RESET; // RULE6
    end else if (!lockSync_ff) begin
      errCnt_ff <= `SPTP_CNT_UNLOCK; // RULE8
    end else if (errCnt_ff == `SPTP_CNT_UNLOCK) begin
      errCnt_ff <= `SPTP_CNT_RESET;
    end else if (cntErr && errCnt_ff < `SPTP_CNT_SAT) begin
      errCnt_ff <= errCnt_ff + 8'h01; // RULE5 RULE7
    end
  end

  // ---------------- interrupts ----------------
  logic [`SPTP_IRQ_BITS-1:0] irqEv, irqClr;
  always_comb begin
    irqEv = '0;
    irqEv[`SPTP_IRQ_ERR] = cntErr;
    irqEv[`SPTP_IRQ_SAT] = patChk && lockSync_ff && errCnt_ff == `SPTP_CNT_SAT;
    irqEv[`SPTP_IRQ_UNLOCK] = patChk && !lockSync_ff;
    irqClr = (wLane0 && wIdx == `SPTP_IDX_IRQ_CLR) ? wData_ff[`SPTP_IRQ_BITS-1:0] : '0;
  end

  // set beats clear in the same cycle
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      irqSts_ff <= '0;
      irq_ff <= 1'b0;
    end else begin
      irqSts_ff <= (irqSts_ff & ~irqClr) | irqEv;
      irq_ff <= |(irqSts_ff & irqEn_ff);
    end
  end

  // ---------------- outputs ----------------
  assign phyCtrl.rxClkDown = rstOvr_ff[`SPTP_RST_RXCLKDN]; // RULE12
  assign phyCtrl.txClkDown = rstOvr_ff[`SPTP_RST_TXCLKDN]; // RULE13
  assign phyCtrl.rxPllRst = rstOvr_ff[`SPTP_RST_RXPLLRST]; // RULE14
  assign phyCtrl.txPllRst = rstOvr_ff[`SPTP_RST_TXPLLRST]; // RULE15
  assign phyCtrl.rxPllInit = rstOvr_ff[`SPTP_RST_RXINIT]; // RULE16
  assign phyCtrl.txPllInit = rstOvr_ff[`SPTP_RST_TXINIT]; // RULE16
  assign phyCtrl.rxHiz = rstOvr_ff[`SPTP_RST_RXHIZ]; // RULE17
  assign phyCtrl.txHiz = rstOvr_ff[`SPTP_RST_TXHIZ]; // RULE17
  assign phyCtrl.rxPwrDn = pwrOvr_ff[`SPTP_PWR_RXPD]; // RULE18
  assign phyCtrl.nearLoop = patLoop; // RULE3
  assign txData = txData_ff;
  assign irq = irq_ff;
  assign s_axi_awready = awRdy_ff;
  assign s_axi_wready = wRdy_ff;
  assign s_axi_bvalid = bValid_ff;
  assign s_axi_bresp = bResp_ff;
  assign s_axi_arready = arRdy_ff;
  assign s_axi_rvalid = rValid_ff;
  assign s_axi_rdata = rData_ff;
  assign s_axi_rresp = rResp_ff;

  // ---------------- assertions ----------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_patWrite;
    wLane0 && wIdx == `SPTP_IDX_PAT_CTRL;
  endsequence

  a_ctrl_write_now: assert property (s_patWrite |=> // RULE11
    patCtrl_ff == ($past(wData_ff[7:0]) & `SPTP_PAT_WMASK))
    else $error("pattern control write did not land next cycle");
  a_chk_off_clear: assert property (!patChk |=> errCnt_ff == 8'h00) // RULE6
    else $error("counter not cleared with checker off");
  a_unlock_code: assert property (patChk && !lockSync_ff |=> errCnt_ff == 8'hff) // RULE8
    else $error("unlock code not shown");
  a_sat_hold: assert property (patChk && lockSync_ff && errCnt_ff == 8'hfe |=> // RULE7
    errCnt_ff inside {8'hfe, 8'h00, 8'hff})
    else $error("counter left saturation");
  a_cnt_no_wrap: assert property (patChk && lockSync_ff && errCnt_ff != 8'hff ##1 patChk |-> // RULE7
    errCnt_ff >= $past(errCnt_ff) || errCnt_ff == 8'hff)
    else $error("counter wrapped");
  a_err_count: assert property (cntErr && lockSync_ff && errCnt_ff < 8'hfe |=> // RULE5
    errCnt_ff == $past(errCnt_ff) + 8'h01)
    else $error("error not counted");
  a_zero_invariant: assert property (chkStep && warmDone && errCnt_ff < 8'hfe && // RULE10
    (nxt_chkH & lenMask(patTyp)) == 31'h00000000 |=> errCnt_ff == $past(errCnt_ff) + 8'h01)
    else $error("all-zero stream not flagged");
  a_gen_idle: assert property (!patGen |=> txData == $past(txUserData)) // RULE4
    else $error("pattern sent while generator off");
  a_loop_feed: assert property (patLoop && patChk && lockSync_ff && rxRun |-> // RULE3
    chkStep && rxIn == txData)
    else $error("loopback not feeding receiver");
  a_rx_down_stop: assert property (patChk && lockSync_ff && errCnt_ff != 8'hff && // RULE12
    (phyCtrl.rxClkDown || phyCtrl.rxPwrDn || phyCtrl.rxPllRst) |=> errCnt_ff == $past(errCnt_ff))
    else $error("checker running with receive path down");
  a_irq_follow: assert property ($rose(irqSts_ff[0]) && irqEn_ff[0] |-> ##1 irq)
    else $error("interrupt not raised");
  // readies stay low until the response has been taken
  a_write_resp: assert property (doWrite |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready)
    else $error("write response missing");
endmodule
`default_nettype wire

// File: sptp_far_lane.sv
`timescale 1ns/1ps
`default_nettype none
module sptp_far_lane #(
  parameter int W = 16
) (
  input wire logic sys_clk,
  input wire logic [1:0] typ,
  input wire logic run,
  input wire logic [W-1:0] flipMask,
  output logic [W-1:0] rxData,
  output logic rxValid
);
  int tapA[4] = '{7, 11, 23, 31};
  int tapB[4] = '{6, 9, 18, 28};
  logic [30:0] hist = 31'h7fffffff;
  logic [W-1:0] word;
  logic nb;
  initial begin
    rxData = '0;
    rxValid = 1'b0;
  end
  // idle line is not driven, so it must not look like held data
  always @(posedge sys_clk) begin
    if (run) begin
      for (int i = 0; i < W; i++) begin
        nb = hist[tapA[typ]-1] ^ hist[tapB[typ]-1];
        hist = {hist[29:0], nb};
        word[i] = nb;
      end
      rxData <= word ^ flipMask;
      rxValid <= 1'b1;
    end else begin
      rxData <= ~rxData;
      rxValid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// File: tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "sptp_defs.svh"
module tb
  import sptp_pkg::*;
();
  logic sys_clk = 0, rst_n = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, rxValid, irq, run = 0, cdrLocked = 1, ok;
  logic [11:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata, d, v, p;
  logic [1:0] bresp, rresp, r, typ = '0;
  logic [15:0] txUserData = '0, txData, rxData, flipMask = '0;
  logic [30:0] mh = '0;
  logic [79:0] bits;
  sptp_phy_ctrl_t phyCtrl;
  int miscompares = 0, testsRun = 0, seed = 85750, mFill, mErr, mTyp, k, t;
  int tapA[4] = '{7, 11, 23, 31};
  int tapB[4] = '{6, 9, 18, 28};
  bit mChk = 0;
  always #50 sys_clk = ~sys_clk;
  sptp_lane_ctrl #(.W(16), .ADDR_W(12)) u_sptp_lane_ctrl (
    .sys_clk(sys_clk), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .txUserData(txUserData), .txData(txData), .rxData(rxData), .rxValid(rxValid),
    .cdrLocked(cdrLocked), .phyCtrl(phyCtrl), .irq(irq));
  sptp_far_lane #(.W(16)) u_sptp_far_lane (
    .sys_clk(sys_clk), .typ(typ), .run(run), .flipMask(flipMask), .rxData(rxData),
    .rxValid(rxValid));
  // one error per step however many bits differ; first two steps only fill
  always @(posedge sys_clk) begin : mdl
    bit mis;
    mis = 0;
    if (mChk && rxValid) begin
      for (int i = 0; i < 16; i++) begin
        if (mFill >= 2 && rxData[i] !== (mh[tapA[mTyp]-1] ^ mh[tapB[mTyp]-1])) mis = 1;
        mh = {mh[29:0], rxData[i]};
      end
      if (mFill < 2) mFill++;
      else if ((mis || 31'(mh << (31 - tapA[mTyp])) == 31'h0) && mErr < 254) mErr++;
    end
  end
  task automatic chkReg(input logic [31:0] g, input logic [31:0] e);
    testsRun++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value at %0t: reg %h expected %h", $time, g, e);
    end
  endtask
  task automatic chkPin(input logic [31:0] g, input logic [31:0] e);
    testsRun++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value at %0t: pin %h expected %h", $time, g, e);
    end
  endtask
  task automatic results();
    $display("comparisons %0d miscompares %0d", testsRun, miscompares);
    if (miscompares == 0 && testsRun > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic hang();
    miscompares++;
    results();
  endtask
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask
  task automatic axw(input logic [11:0] a, input logic [31:0] dw, input logic [1:0] er);
    bit ha, hw, hb, dA, dW;
    dA = 0;
    dW = 0;
    hb = 0;
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= dw;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    for (int n = 0; n < 50 && !hb; n++) begin
      @(negedge sys_clk);
      ha = !dA && awready === 1'b1;
      hw = !dW && wready === 1'b1;
      hb = bvalid === 1'b1;
      if (hb) chkReg({30'h0, bresp}, {30'h0, er});
      @(posedge sys_clk);
      if (ha) awvalid <= 0;
      if (hw) wvalid <= 0;
      if (hb) bready <= 0;
      dA = dA | ha;
      dW = dW | hw;
    end
    if (!hb) hang();
  endtask
  task automatic axr(input logic [11:0] a, output logic [31:0] dr, output logic [1:0] rr);
    bit ha, hr, dA;
    dA = 0;
    hr = 0;
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    for (int n = 0; n < 50 && !hr; n++) begin
      @(negedge sys_clk);
      ha = !dA && arready === 1'b1;
      hr = rvalid === 1'b1;
      dr = rdata;
      rr = rresp;
      @(posedge sys_clk);
      if (ha) arvalid <= 0;
      if (hr) rready <= 0;
      dA = dA | ha;
    end
    if (!hr) hang();
  endtask
  task automatic rdChk(input logic [11:0] a, input logic [31:0] e);
    axr(a, d, r);
    chkReg(d, e);
  endtask
  initial begin
    repeat (12) @(posedge sys_clk);
    rst_n <= 1;
    repeat (2) @(posedge sys_clk);
    chkPin({22'h0, phyCtrl}, 0);
    for (k = 0; k < 6; k++) rdChk(12'h100 + 12'(4 * k), 0);
    axr(12'h11c, d, r);
    chkReg({30'h0, r}, {30'h0, `SPTP_RESP_SLVERR});
    axw(12'h200, 32'hff, `SPTP_RESP_SLVERR);
    axw(12'h104, 32'h55, `SPTP_RESP_OKAY);
    rdChk(12'h104, 0);
    done("registers");
    for (t = 0; t < 4; t++) begin
      axw(12'h100, 32'(t * 4 + 1), `SPTP_RESP_OKAY);
      repeat (2) @(posedge sys_clk);
      for (k = 0; k < 5; k++) begin
        @(negedge sys_clk);
        bits[k*16+:16] = txData;
      end
      ok = bits != 0;
      for (k = tapA[t]; k < 80; k++) if (bits[k] !== (bits[k-tapA[t]] ^ bits[k-tapB[t]])) ok = 0;
      chkPin({31'h0, ok}, 1);
    end
    axw(12'h100, 0, `SPTP_RESP_OKAY);
    v = $random(seed);
    @(posedge sys_clk);
    txUserData <= v[15:0];
    repeat (6) begin
      @(posedge sys_clk);
      p = v;
      v = $random(seed);
      txUserData <= v[15:0];
      @(negedge sys_clk);
      chkPin({16'h0, txData}, {16'h0, p[15:0]});
    end
    txUserData <= 0;
    done("generator");
    for (t = 0; t < 4; t++) begin
      axw(12'h100, 32'(t * 4 + 64), `SPTP_RESP_OKAY);
      mTyp = t;
      mFill = 0;
      mErr = 0;
      mChk = 1;
      @(posedge sys_clk);
      typ <= 2'(t);
      run <= 1;
      repeat (30) begin
        @(posedge sys_clk);
        flipMask <= ($random(seed) & 7) == 0 ? 16'h1 << ($random(seed) & 15) : 16'h0;
      end
      @(posedge sys_clk);
      run <= 0;
      flipMask <= 0;
      repeat (4) @(posedge sys_clk);
      rdChk(12'h104, 32'(mErr));
      axw(12'h100, 0, `SPTP_RESP_OKAY);
      mChk = 0;
      rdChk(12'h104, 0);
    end
    done("checker");
    axw(12'h100, 32'h40, `SPTP_RESP_OKAY);
    cdrLocked <= 0;
    d = 0;
    // lock is resynchronised, so poll a bounded number of times
    for (k = 0; k < 10 && d !== 32'hff; k++) axr(12'h104, d, r);
    chkReg(d, 32'hff);
    cdrLocked <= 1;
    repeat (5) @(posedge sys_clk);
    rdChk(12'h104, 0);
    axw(12'h100, 0, `SPTP_RESP_OKAY);
    axw(12'h118, 7, `SPTP_RESP_OKAY);
    rdChk(12'h110, 0);
    done("lock");
    axw(12'h100, 32'h42, `SPTP_RESP_OKAY);
    repeat (300) @(posedge sys_clk);
    rdChk(12'h104, 32'hfe);
    repeat (40) @(posedge sys_clk);
    rdChk(12'h104, 32'hfe);
    rdChk(12'h110, 3);
    @(negedge sys_clk);
    chkPin({31'h0, irq}, 0);
    axw(12'h114, 2, `SPTP_RESP_OKAY);
    repeat (2) @(negedge sys_clk);
    chkPin({31'h0, irq}, 1);
    axw(12'h100, 0, `SPTP_RESP_OKAY);
    rdChk(12'h104, 0);
    axw(12'h118, 7, `SPTP_RESP_OKAY);
    rdChk(12'h110, 0);
    @(negedge sys_clk);
    chkPin({31'h0, irq}, 0);
    done("loopback");
    for (k = 0; k < 4; k++) begin
      v = $random(seed);
      axw(12'h108, v, `SPTP_RESP_OKAY);
      axw(12'h10c, v >> 8, `SPTP_RESP_OKAY);
      axw(12'h100, v >> 16, `SPTP_RESP_OKAY);
      rdChk(12'h108, {24'h0, v[7:0]});
      rdChk(12'h10c, {31'h0, v[8]});
      rdChk(12'h100, {24'h0, v[23:16] & 8'h4f});
      chkPin({22'h0, phyCtrl}, {22'h0, v[7:0], v[8], v[17]});
    end
    // transmit clock down: the generator must not move
    axw(12'h108, 32'h40, `SPTP_RESP_OKAY);
    axw(12'h100, 1, `SPTP_RESP_OKAY);
    @(negedge sys_clk);
    p = {16'h0, txData};
    repeat (3) @(negedge sys_clk);
    chkPin({16'h0, txData}, p);
    done("overrides");
    results();
  end
endmodule
`default_nettype wire
